// [src/e1mc_map.svh]
// Address map, field positions, reset values and counts of the master control page
`ifndef E1MC_MAP_SVH
`define E1MC_MAP_SVH

// Register offsets on the five-bit microprocessor address
`define E1MC_OFS_DATALINK_SELECT   5'h10
`define E1MC_OFS_MODE_SELECT       5'h11
`define E1MC_OFS_NONFRAME_ALIGN    5'h12
`define E1MC_OFS_TX_MF_ALIGN       5'h13
`define E1MC_OFS_LINK_CTRL_SELECT  5'h14
`define E1MC_OFS_CODING_LOOPBACK   5'h15
`define E1MC_OFS_TX_ALARM_CTRL     5'h16
`define E1MC_OFS_RESERVED_17       5'h17
`define E1MC_OFS_UNUSED_18         5'h18
`define E1MC_OFS_NATBIT_IRQ_MASK   5'h19
`define E1MC_OFS_IRQ_SIG_TEST      5'h1A
`define E1MC_OFS_IRQ_MASK_ZERO     5'h1B
`define E1MC_OFS_IRQ_MASK_ONE      5'h1C
`define E1MC_OFS_IRQ_MASK_TWO      5'h1D
`define E1MC_OFS_IRQ_MASK_THREE    5'h1E
`define E1MC_OFS_TX_PULSE_CTRL     5'h1F

// Page-select bit of the address
`define E1MC_PAGE_BIT              4

// Fields of the data-link selection word
`define E1MC_BIT_ALARM_CRITERION   7
`define E1MC_BIT_MF_OUTPUT_SEL     6
`define E1MC_BIT_NAT_BUFFER_SEL    5
`define E1MC_FLD_SPARE_SEL_HI      4
`define E1MC_FLD_SPARE_SEL_LO      0

// Fields of the mode selection word and the non-frame-alignment word
`define E1MC_BIT_TX_TRANSPARENT    2
`define E1MC_FLD_NAT_USE_HI        4
`define E1MC_FLD_NAT_USE_LO        0

// Spare-bit select forced in transparent mode: first spare bit only
`define E1MC_SPARE_SEL_TRANSPARENT 5'h10

// Reset values
`define E1MC_RST_ZERO              8'h00
`define E1MC_RST_NONFRAME_ALIGN    8'hBF

// Alarm window: two frames of 256 bits, fewer than three zeros
`define E1MC_AIS_WINDOW_BITS       512
`define E1MC_AIS_ZERO_LIMIT        3

`endif

// [src/e1mc_pkg.sv]
// Types shared by the master control page modules
package e1mc_pkg;

	// One control byte
	typedef logic [7:0] e1mc_byte_t;

	// Five spare bits of the non-frame-alignment signal
	typedef logic [4:0] e1mc_spare_t;

	// Register page address
	typedef logic [4:0] e1mc_addr_t;

endpackage : e1mc_pkg

// [src/e1mc_ais_if.sv]
// Connection between the control page and the alarm signal detector
`timescale 1ns/1ps

interface e1mc_ais_if;
	logic rxBit;         // Received line bit
	logic rxBitValid;    // One-cycle strobe per received bit
	logic windowStart;   // Marks first bit of a double frame
	logic criterionSel;  // Alarm criterion select
	logic aisValid;      // Alarm indication signal declared

	modport page (output rxBit, output rxBitValid, output windowStart, output criterionSel, input aisValid);
	modport detector (input rxBit, input rxBitValid, input windowStart, input criterionSel, output aisValid);
endinterface : e1mc_ais_if

// [src/e1mc_ais_det.sv]
// Alarm indication signal detector over double-frame windows
`timescale 1ns/1ps

`include "e1mc_map.svh"

module e1mc_ais_det
	import e1mc_pkg::*;
#(
	parameter int WINDOW_BITS = `E1MC_AIS_WINDOW_BITS,
	parameter int ZERO_LIMIT  = `E1MC_AIS_ZERO_LIMIT
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Detector side of the link to the page
	e1mc_ais_if.detector ais
);

	localparam int CW = $clog2(WINDOW_BITS);

	logic [CW-1:0] bitCnt_q;      // Bit position inside the window
	logic [1:0]    zeroCnt_q;     // Zeros seen, saturates at three
	logic          prevOk_q;      // Previous window met the criterion
	logic          aisValid_q;    // Declared alarm

	// Window closes on its last bit or when the framer restarts it
	wire logic lastBit   = ais.rxBitValid && (bitCnt_q == CW'(WINDOW_BITS - 1));
	wire logic bitZero   = ais.rxBitValid && !ais.rxBit;
	wire logic [1:0] zeroNow = (bitZero && zeroCnt_q != 2'(ZERO_LIMIT)) ? zeroCnt_q + 2'h1 : zeroCnt_q;
	wire logic windowOk  = (zeroNow < 2'(ZERO_LIMIT));

	// Count bits and zeros, decide on the last bit of each window; a restart decides nothing
	always_ff @(posedge clk) begin
		if (rst) begin
			bitCnt_q   <= '0;
			zeroCnt_q  <= 2'h0;
			prevOk_q   <= 1'b0;
			aisValid_q <= 1'b0;
		end else if (ais.windowStart) begin
			// Realign to the framer; a partial window is discarded, and a bit
			// arriving with the marker is the first bit of the new window
			bitCnt_q  <= ais.rxBitValid ? CW'(1) : CW'(0);
			zeroCnt_q <= bitZero ? 2'h1 : 2'h0;
		end else if (lastBit) begin
			bitCnt_q  <= '0;
			zeroCnt_q <= 2'h0;
			prevOk_q  <= windowOk;
			// Single window, or two in a row for the stricter criterion
			if (ais.criterionSel) begin
				aisValid_q <= windowOk && prevOk_q;
			end else begin
				aisValid_q <= windowOk;
			end
		end else if (ais.rxBitValid) begin
			bitCnt_q  <= bitCnt_q + CW'(1);
			zeroCnt_q <= zeroNow;
		end
	end

	assign ais.aisValid = aisValid_q;

endmodule : e1mc_ais_det

// [src/e1mc_ctrl_page.sv]
// Master control page: register bank on the parallel port and its selection logic
//
// How it works
// - Clear criterion: under three zeros per 512 bits.
// - Set criterion: two consecutive windows under three zeros.
// - Marker follows signalling or CRC-4 multiframe per select.
// - Buffer select picks national buffer or control word.
// - Each spare select bit routes that bit to link.
// - Spare selection only in termination; transparent forces first.
// - Transparent bit disables framing; clear means termination mode.
// - National-use bits feed spare positions, reset all ones.
`timescale 1ns/1ps

`include "e1mc_map.svh"

module e1mc_ctrl_page
	import e1mc_pkg::*;
(
	// Clock and reset
	clk,
	rst,
	// Parallel microprocessor port
	busCsN,
	busRdN,
	busWrN,
	busAddr,
	busDataIn,
	busDataOut,
	busDataOe,
	// Receive framer side
	rxBit,
	rxBitValid,
	rxDoubleFrameStart,
	rxSigMultiframe,
	rxCrcMultiframe,
	// Transmit framer side
	txNatBuffer,
	txDataLink,
	// Results
	aisDetected,
	rxMultiframeMarker,
	txSpareBits,
	txSpareIsLink,
	txTransparent
);
	// Clock and reset
	input  wire logic        clk;                 // 40 MHz system clock
	input  wire logic        rst;                 // Synchronous, active high
	// Parallel microprocessor port
	input  wire logic        busCsN;              // Chip select, active low
	input  wire logic        busRdN;              // Read strobe, active low
	input  wire logic        busWrN;              // Write strobe, active low
	input  wire e1mc_addr_t  busAddr;             // Register address
	input  wire e1mc_byte_t  busDataIn;           // Data from host
	output logic [7:0]       busDataOut;          // Data to host
	output logic             busDataOe;           // High while driving data
	// Receive framer side
	input  wire logic        rxBit;               // Received bit
	input  wire logic        rxBitValid;          // Strobe per received bit
	input  wire logic        rxDoubleFrameStart;  // First bit of double frame
	input  wire logic        rxSigMultiframe;     // Signalling multiframe pulse
	input  wire logic        rxCrcMultiframe;     // CRC-4 multiframe pulse
	// Transmit framer side
	input  wire e1mc_spare_t txNatBuffer;         // National bit buffer output
	input  wire e1mc_spare_t txDataLink;          // Data link bits
	// Results
	output logic             aisDetected;         // Alarm indication signal
	output logic             rxMultiframeMarker;  // Receive multiframe output
	output logic [4:0]       txSpareBits;         // Spare bits to transmit
	output logic [4:0]       txSpareIsLink;       // Per-bit data link routing
	output logic             txTransparent;       // Transparent transmit mode

	// Page storage, index is the low four address bits
	e1mc_byte_t regs_q [16];

	// Port synchronisers: two stages before any logic looks
	logic [2:0]  ctlMeta_q;     // First stage of strobes
	logic [2:0]  ctlSync_q;     // Second stage of strobes
	e1mc_addr_t  addrMeta_q;    // First stage of address
	e1mc_addr_t  addrSync_q;    // Second stage of address
	e1mc_byte_t  dataMeta_q;    // First stage of write data
	e1mc_byte_t  dataSync_q;    // Second stage of write data
	logic        wrPrev_q;      // Write active last cycle

	// Output flops
	e1mc_byte_t  dataOut_q;
	logic        dataOe_q;
	logic        mfMarker_q;
	e1mc_spare_t spareBits_q;
	e1mc_spare_t spareLink_q;
	logic        transparent_q;

	// Interface to the alarm detector
	e1mc_ais_if aisBus ();

	// Address and data pass the same two stages as the strobes, so the host must
	// keep them steady for the whole low pulse; a bit that moves while the strobe
	// is low could be taken from either value
	// Decoded strobes after synchronisation
	wire logic csActive = !ctlSync_q[2];
	wire logic rdActive = csActive && !ctlSync_q[1];
	wire logic wrActive = csActive && !ctlSync_q[0];
	// Write takes effect once, on the strobe's leading edge
	wire logic wrTake   = wrActive && !wrPrev_q;
	// Only the upper half of the address space is this page
	wire logic onPage   = addrSync_q[`E1MC_PAGE_BIT];
	wire logic [3:0] regIdx = addrSync_q[3:0];
	wire logic isUnused = (addrSync_q == `E1MC_OFS_UNUSED_18);
	wire e1mc_byte_t rdData = (onPage && !isUnused) ? regs_q[regIdx] : 8'h00;

	// Fields that steer the block
	wire e1mc_byte_t dlWord   = regs_q[4'(`E1MC_OFS_DATALINK_SELECT)];
	wire e1mc_byte_t modeWord = regs_q[4'(`E1MC_OFS_MODE_SELECT)];
	wire e1mc_byte_t nfaWord  = regs_q[4'(`E1MC_OFS_NONFRAME_ALIGN)];
	wire logic alarmCriterionSelect   = dlWord[`E1MC_BIT_ALARM_CRITERION];
	wire logic multiframeOutputSelect = dlWord[`E1MC_BIT_MF_OUTPUT_SEL];
	wire logic nationalBufferSelect   = dlWord[`E1MC_BIT_NAT_BUFFER_SEL];
	wire logic txTransparentSelect    = modeWord[`E1MC_BIT_TX_TRANSPARENT];
	wire e1mc_spare_t txNationalUseBits = nfaWord[`E1MC_FLD_NAT_USE_HI:`E1MC_FLD_NAT_USE_LO];
	// Termination mode honours the field; transparent forces the first spare bit
	wire e1mc_spare_t spareBitLinkSelect = txTransparentSelect ? `E1MC_SPARE_SEL_TRANSPARENT
		: dlWord[`E1MC_FLD_SPARE_SEL_HI:`E1MC_FLD_SPARE_SEL_LO];
	// Non-link spare bits come from the buffer or the control word
	wire e1mc_spare_t spareSource = nationalBufferSelect ? txNatBuffer : txNationalUseBits;
	// Marker source, selected per multiframe kind
	wire logic mfSource = multiframeOutputSelect ? rxCrcMultiframe : rxSigMultiframe;
	e1mc_spare_t spareNext;

	// Per spare bit: data link when selected, else the programmed source
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_spare
			assign spareNext[gi] = spareBitLinkSelect[gi] ? txDataLink[gi] : spareSource[gi];
		end
	endgenerate

	// Two-stage capture of the asynchronous port pins
	always_ff @(posedge clk) begin
		if (rst) begin
			ctlMeta_q  <= 3'h7;
			ctlSync_q  <= 3'h7;
			addrMeta_q <= 5'h00;
			addrSync_q <= 5'h00;
			dataMeta_q <= 8'h00;
			dataSync_q <= 8'h00;
			wrPrev_q   <= 1'b0;
		end else begin
			ctlMeta_q  <= {busCsN, busRdN, busWrN};
			ctlSync_q  <= ctlMeta_q;
			addrMeta_q <= busAddr;
			addrSync_q <= addrMeta_q;
			dataMeta_q <= busDataIn;
			dataSync_q <= dataMeta_q;
			wrPrev_q   <= wrActive;
		end
	end

	// Register storage; reserved word is stored as written, host keeps it zero
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				regs_q[i] <= `E1MC_RST_ZERO;
			end
			regs_q[4'(`E1MC_OFS_NONFRAME_ALIGN)] <= `E1MC_RST_NONFRAME_ALIGN;
		end else if (wrTake && onPage && !isUnused) begin
			regs_q[regIdx] <= dataSync_q;
		end
	end

	// Read data and drive enable, held while the read strobe is low
	always_ff @(posedge clk) begin
		if (rst) begin
			dataOut_q <= 8'h00;
			dataOe_q  <= 1'b0;
		end else begin
			dataOut_q <= rdData;
			dataOe_q  <= rdActive;
		end
	end

	// Framer-facing selections, registered so outputs come from flops
	always_ff @(posedge clk) begin
		if (rst) begin
			mfMarker_q    <= 1'b0;
			spareBits_q   <= 5'h1F;
			spareLink_q   <= 5'h00;
			transparent_q <= 1'b0;
		end else begin
			mfMarker_q    <= mfSource;
			spareBits_q   <= spareNext;
			spareLink_q   <= spareBitLinkSelect;
			transparent_q <= txTransparentSelect;
		end
	end

	// Alarm detector feed
	assign aisBus.rxBit        = rxBit;
	assign aisBus.rxBitValid   = rxBitValid;
	assign aisBus.windowStart  = rxDoubleFrameStart;
	assign aisBus.criterionSel = alarmCriterionSelect;

	e1mc_ais_det u_ais (
		.clk (clk),
		.rst (rst),
		.ais (aisBus.detector)
	);

	// Outputs straight from flops
	assign busDataOut         = dataOut_q;
	assign busDataOe          = dataOe_q;
	assign aisDetected        = aisBus.aisValid;
	assign rxMultiframeMarker = mfMarker_q;
	assign txSpareBits        = spareBits_q;
	assign txSpareIsLink      = spareLink_q;
	assign txTransparent      = transparent_q;

endmodule : e1mc_ctrl_page

// [verif/e1mc_ctrl_page_chk.sv]
// Port-level checks on the master control page
`timescale 1ns/1ps

module e1mc_ctrl_page_chk
	import e1mc_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Bus pins
	input wire logic        busRdN,
	input wire logic        busCsN,
	input wire logic        busDataOe,
	// Framer side
	input wire logic        rxBitValid,
	input wire logic        rxSigMultiframe,
	input wire logic        rxCrcMultiframe,
	input wire e1mc_spare_t txDataLink,
	input wire logic        aisDetected,
	input wire logic        rxMultiframeMarker,
	input wire logic [4:0]  txSpareBits,
	input wire logic [4:0]  txSpareIsLink,
	input wire logic        txTransparent
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Read strobe released long enough to pass the synchroniser
	sequence rdIdle;
		busRdN [*4];
	endsequence

	reset_values_a: assert property ($fell(rst) |-> txSpareBits == 5'h1F && txSpareIsLink == 5'h00
		&& !txTransparent && !busDataOe) else $error("reset output values wrong");
	oe_rise_a: assert property ($rose(busDataOe) |-> $past(busCsN | busRdN, 3) == 1'b0)
		else $error("read data driven without strobe");
	oe_drop_a: assert property (rdIdle |-> !busDataOe) else $error("read data held too long");
	tp_forces_a: assert property (txTransparent |-> txSpareIsLink == 5'h10) else $error("transparent link wrong");
	tp_first_a: assert property (txTransparent && $past(txTransparent) |->
		txSpareBits[4] == $past(txDataLink[4])) else $error("first spare bit not from link");
	link_data_a: assert property (txSpareIsLink == 5'h1F && $past(txSpareIsLink) == 5'h1F |->
		txSpareBits == $past(txDataLink)) else $error("link bits not passed");
	marker_idle_a: assert property (!$past(rxSigMultiframe) && !$past(rxCrcMultiframe) |->
		!rxMultiframeMarker) else $error("marker without source");
	ais_bit_a: assert property ($changed(aisDetected) |-> $past(rxBitValid))
		else $error("alarm moved without a bit");
endmodule : e1mc_ctrl_page_chk

bind e1mc_ctrl_page e1mc_ctrl_page_chk u_e1mc_ctrl_page_chk (.clk(clk), .rst(rst), .busRdN(busRdN),
	.busCsN(busCsN), .busDataOe(busDataOe), .rxBitValid(rxBitValid), .rxSigMultiframe(rxSigMultiframe),
	.rxCrcMultiframe(rxCrcMultiframe), .txDataLink(txDataLink), .aisDetected(aisDetected),
	.rxMultiframeMarker(rxMultiframeMarker), .txSpareBits(txSpareBits), .txSpareIsLink(txSpareIsLink),
	.txTransparent(txTransparent));

// [verif/e1mc_host_model.sv]
// Host microprocessor model on the parallel port
`timescale 1ns/1ps

module e1mc_host_model
	import e1mc_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Parallel port pins
	output logic            busCsN,
	output logic            busRdN,
	output logic            busWrN,
	output e1mc_addr_t      busAddr,
	output e1mc_byte_t      busDataIn,
	input  wire logic [7:0] busDataOut,
	input  wire logic       busDataOe
);
	// Idle pins from time zero
	initial begin
		busCsN = 1'b1;
		busRdN = 1'b1;
		busWrN = 1'b1;
		busAddr = 5'h00;
		busDataIn = 8'h00;
	end

	// Strobes low five clocks, high four: above the synchroniser minimums
	task automatic access(input logic wr, input e1mc_addr_t a, input e1mc_byte_t d, output logic [7:0] q);
		@(posedge clk);
		#1;
		busAddr = a;
		busDataIn = d;
		busCsN = 1'b0;
		busRdN = wr;
		busWrN = !wr;
		repeat (5) @(posedge clk);
		q = busDataOe ? busDataOut : 8'hEE;
		#1;
		busCsN = 1'b1;
		busRdN = 1'b1;
		busWrN = 1'b1;
		// Released lines must not keep the last value
		busAddr = ~a;
		busDataIn = ~d;
		repeat (3) @(posedge clk);
		#1;
	endtask : access
endmodule : e1mc_host_model

// [verif/tb.sv]
// Self-checking bench for the master control page
`timescale 1ns/1ps
`include "e1mc_map.svh"

module tb
	import e1mc_pkg::*;
;
	logic        clk, rst, busCsN, busRdN, busWrN, busDataOe;
	e1mc_addr_t  busAddr;
	e1mc_byte_t  busDataIn;
	logic [7:0]  busDataOut;
	logic        rxBit, rxBitValid, rxDoubleFrameStart, rxSigMultiframe, rxCrcMultiframe;
	logic        aisDetected, rxMultiframeMarker, txTransparent;
	e1mc_spare_t txNatBuffer, txDataLink;
	logic [4:0]  txSpareBits, txSpareIsLink;
	int          numErrors = 0;
	int          checks = 0;
	int          cycles = 0;

	e1mc_ctrl_page u_e1mc_ctrl_page (.clk(clk), .rst(rst), .busCsN(busCsN), .busRdN(busRdN), .busWrN(busWrN),
		.busAddr(busAddr), .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe), .rxBit(rxBit),
		.rxBitValid(rxBitValid), .rxDoubleFrameStart(rxDoubleFrameStart), .rxSigMultiframe(rxSigMultiframe),
		.rxCrcMultiframe(rxCrcMultiframe), .txNatBuffer(txNatBuffer), .txDataLink(txDataLink),
		.aisDetected(aisDetected), .rxMultiframeMarker(rxMultiframeMarker), .txSpareBits(txSpareBits),
		.txSpareIsLink(txSpareIsLink), .txTransparent(txTransparent));
	e1mc_host_model u_e1mc_host_model (.clk(clk), .busCsN(busCsN), .busRdN(busRdN), .busWrN(busWrN),
		.busAddr(busAddr), .busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard: the tests need about 4100 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			report_and_stop;
		end
	end

	task automatic report_and_stop;
		if (numErrors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input e1mc_addr_t a, input e1mc_byte_t d);
		logic [7:0] unused;
		u_e1mc_host_model.access(1'b1, a, d, unused);
	endtask : wr

	task automatic rdc(input e1mc_addr_t a, input logic [7:0] exp);
		logic [7:0] q;
		u_e1mc_host_model.access(1'b0, a, 8'h00, q);
		chk(q, exp);
	endtask : rdc

	// Registered outputs follow one clock after their inputs
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	// One 512-bit window with nz zeros first, then the alarm level
	task automatic feed(input int nz, input logic exp);
		for (int i = 0; i < `E1MC_AIS_WINDOW_BITS; i++) begin
			@(posedge clk);
			#1;
			rxBit = (i >= nz);
			rxBitValid = 1'b1;
		end
		// Drop the strobe right after the last bit is taken, so a window is exactly 512 bits
		@(posedge clk);
		#1;
		rxBitValid = 1'b0;
		settle;
		chk({7'h00, aisDetected}, {7'h00, exp});
	endtask : feed

	initial begin
		rst = 1'b1;
		{rxBit, rxBitValid, rxDoubleFrameStart, rxSigMultiframe, rxCrcMultiframe} = 5'h00;
		txNatBuffer = 5'h0A;
		txDataLink = 5'h0F;
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		rdc(`E1MC_OFS_DATALINK_SELECT, 8'h00);
		rdc(`E1MC_OFS_NONFRAME_ALIGN, 8'hBF);
		chk({3'h0, txSpareBits}, 8'h1F);
		// Write then read back the upper words; reserved gets zero, unused reads zero
		for (int a = 8'h13; a < 8'h20; a++) begin
			wr(e1mc_addr_t'(a), (a == 8'h17) ? 8'h00 : 8'(a) ^ 8'hA5);
			rdc(e1mc_addr_t'(a), (a == 8'h17 || a == 8'h18) ? 8'h00 : 8'(a) ^ 8'hA5);
		end
		wr(5'h05, 8'h3C);
		rdc(5'h05, 8'h00);
		// Spare-bit source: national buffer, then control word
		wr(`E1MC_OFS_DATALINK_SELECT, 8'h20);
		chk({3'h0, txSpareBits}, 8'h0A);
		wr(`E1MC_OFS_NONFRAME_ALIGN, 8'hB5);
		wr(`E1MC_OFS_DATALINK_SELECT, 8'h00);
		chk({3'h0, txSpareBits}, 8'h15);
		// Mixed link routing in termination mode
		wr(`E1MC_OFS_DATALINK_SELECT, 8'h15);
		chk({3'h0, txSpareIsLink}, 8'h15);
		chk({3'h0, txSpareBits}, 8'h05);
		txDataLink = 5'h10;
		settle;
		chk({3'h0, txSpareBits}, 8'h10);
		// Transparent mode overrides the field
		wr(`E1MC_OFS_MODE_SELECT, 8'h04);
		chk({7'h00, txTransparent}, 8'h01);
		chk({3'h0, txSpareBits}, 8'h15);
		wr(`E1MC_OFS_MODE_SELECT, 8'h00);
		chk({3'h0, txSpareIsLink}, 8'h15);
		// Every spare bit routed to the link in termination mode
		wr(`E1MC_OFS_DATALINK_SELECT, 8'h1F);
		chk({3'h0, txSpareIsLink}, 8'h1F);
		chk({3'h0, txSpareBits}, 8'h10);
		txDataLink = 5'h0F;
		settle;
		chk({3'h0, txSpareBits}, 8'h0F);
		// Multiframe marker source
		rxSigMultiframe = 1'b1;
		settle;
		chk({7'h00, rxMultiframeMarker}, 8'h01);
		wr(`E1MC_OFS_DATALINK_SELECT, 8'h40);
		chk({7'h00, rxMultiframeMarker}, 8'h00);
		{rxSigMultiframe, rxCrcMultiframe} = 2'h1;
		settle;
		chk({7'h00, rxMultiframeMarker}, 8'h01);
		// Alarm criteria on single and paired windows
		wr(`E1MC_OFS_DATALINK_SELECT, 8'h00);
		feed(0, 1'b1);
		feed(3, 1'b0);
		feed(2, 1'b1);
		wr(`E1MC_OFS_DATALINK_SELECT, 8'h80);
		feed(3, 1'b0);
		feed(2, 1'b0);
		feed(0, 1'b1);
		// A restart drops a partial window of zeros without a decision
		for (int i = 0; i < 100; i++) begin
			@(posedge clk);
			#1;
			rxBit = 1'b0;
			rxBitValid = 1'b1;
		end
		@(posedge clk);
		#1;
		rxBitValid = 1'b0;
		rxDoubleFrameStart = 1'b1;
		@(posedge clk);
		#1;
		rxDoubleFrameStart = 1'b0;
		chk({7'h00, aisDetected}, 8'h01);
		feed(2, 1'b1);
		// Reset in mid-run restores the selection words and the outputs
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		chk({7'h00, aisDetected}, 8'h00);
		chk({3'h0, txSpareBits}, 8'h1F);
		rdc(`E1MC_OFS_DATALINK_SELECT, 8'h00);
		rdc(`E1MC_OFS_NONFRAME_ALIGN, 8'hBF);
		report_and_stop;
	end
endmodule : tb
